/* File: src/nvmwp_gate.sv */
// Nonvolatile write gate: protection checks, unlock sequence, write timing
`timescale 1ns/10ps
`include "nvmwp_params.svh"
module nvmwp_gate #(
   parameter int unsigned PWRT_CYCLES = `NVMWP_PWRT_CYCLES,
   parameter int unsigned WRITE_CYCLES = `NVMWP_WRITE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire nvmwp_pkg::nvmwp_addr_t reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic pwrt_enable,
   input wire logic prog_erase_all,
   input wire logic prog_cfg_wr,
   input wire logic [3:0] prog_cfg_data,
   input wire logic prog_rd_req,
   input wire logic prog_wr_req,
   input wire logic prog_is_data,
   input wire logic prog_area_protected,
   input wire logic fw_area_protected,
   output logic prog_rd_grant,
   output logic prog_wr_grant,
   output logic fw_prog_rd_grant,
   output logic fetch_grant,
   output logic [3:0] cfg_bits,
   output logic mem_wr_strobe,
   output logic mem_wr_is_prog,
   output logic [12:0] mem_wr_addr,
   output logic [13:0] mem_wr_data,
   output logic nvm_write_done_flag
);
   import nvmwp_pkg::*;

   localparam int unsigned PW_W = $clog2(PWRT_CYCLES + 1);
   localparam int unsigned WC_W = $clog2(WRITE_CYCLES + 1);

   // Config bits: [3] data protect, [2] high, [1] low program protect, [0] write allow
   logic [3:0] cfg_r;
   logic data_code_protect_bit;
   logic program_protect_bit_high;
   logic program_protect_bit_low;
   logic program_write_allow_bit;
   logic [7:0] data_lo_r, data_hi_r, addr_lo_r, addr_hi_r;
   logic [7:0] interrupt_control_r, peripheral_enable_two_r;
   logic write_enable_latch_r;
   logic program_memory_select_r;
   logic write_error_flag_r;
   logic write_busy_r;
   logic nvm_write_done_flag_r;
   logic wr_blocked_r;
   logic [PW_W-1:0] pwrt_cnt_r;
   logic [WC_W-1:0] wr_cnt_r;
   nvmwp_unlock_t unlock_r;
   nvmwp_wr_state_t wr_state_r;
   logic pwrt_running;
   logic start_req;
   logic start_ok;
   logic fw_prog_write_ok;
   logic write_end;

   function automatic logic hit(input nvmwp_addr_t a, input nvmwp_addr_t off);
      hit = (a == off);
   endfunction

   assign data_code_protect_bit = cfg_r[3];
   assign program_protect_bit_high = cfg_r[2];
   assign program_protect_bit_low = cfg_r[1];
   assign program_write_allow_bit = cfg_r[0];
   assign cfg_bits = cfg_r;

   // Bits may only go from 1 to 0 until a full erase or a reset restores them
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_r <= `NVMWP_CFG_ERASED;
      end else if (prog_erase_all) begin
         cfg_r <= `NVMWP_CFG_ERASED;
      end else if (prog_cfg_wr && data_code_protect_bit) begin
         cfg_r <= cfg_r & prog_cfg_data;
      end
   end

   // Power-up timer counts only after reset; reset is power-on here
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pwrt_cnt_r <= '0;
      end else if (pwrt_enable && pwrt_cnt_r != PW_W'(PWRT_CYCLES)) begin
         pwrt_cnt_r <= pwrt_cnt_r + PW_W'(1);
      end
   end
   assign pwrt_running = pwrt_enable && (pwrt_cnt_r != PW_W'(PWRT_CYCLES));

   // External port: data protect kills all access
   always_comb begin
      prog_rd_grant = 1'b0;
      prog_wr_grant = 1'b0;
      if (data_code_protect_bit) begin
         if (prog_is_data) begin
            prog_rd_grant = prog_rd_req;
            prog_wr_grant = prog_wr_req;
         end else begin
            case ({program_protect_bit_high, program_protect_bit_low})
               2'b11: prog_rd_grant = prog_rd_req;
               2'b01, 2'b10: prog_rd_grant = prog_rd_req && !prog_area_protected;
               default: prog_rd_grant = 1'b0;
            endcase
            prog_wr_grant = prog_wr_req && program_protect_bit_high
               && program_protect_bit_low;
         end
      end
   end

   assign fw_prog_rd_grant = 1'b1;
   assign fetch_grant = 1'b1;

   always_comb begin
      case ({program_protect_bit_high, program_protect_bit_low})
         2'b11: fw_prog_write_ok = program_write_allow_bit;
         2'b01, 2'b10: fw_prog_write_ok = program_write_allow_bit && !fw_area_protected;
         default: fw_prog_write_ok = 1'b0;
      endcase
   end

   assign start_req = reg_wr && hit(reg_addr, `NVMWP_OFF_CTRL)
      && reg_wdata[`NVMWP_CTRL_WR] && !write_busy_r;
   // Data EEPROM writes never consult data protect
   assign start_ok = write_enable_latch_r && unlock_r == NVMWP_ARMED && !pwrt_running
      && (!program_memory_select_r || fw_prog_write_ok);

   // Unlock: 55h then AAh to the unlock port, any write to a register other than the control register breaks it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         unlock_r <= NVMWP_LOCKED;
      end else if (start_req) begin
         unlock_r <= NVMWP_LOCKED;
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_UNLOCK)) begin
         case (unlock_r)
            NVMWP_LOCKED: unlock_r <= (reg_wdata == `NVMWP_UNLOCK_KEY1)
               ? NVMWP_KEY1_SEEN : NVMWP_LOCKED;
            NVMWP_KEY1_SEEN: unlock_r <= (reg_wdata == `NVMWP_UNLOCK_KEY2)
               ? NVMWP_ARMED : NVMWP_LOCKED;
            default: unlock_r <= NVMWP_LOCKED;
         endcase
      end else if (reg_wr && !hit(reg_addr, `NVMWP_OFF_CTRL)) begin
         unlock_r <= NVMWP_LOCKED;
      end
   end

   // A latch set in the same write as the start bit does not enable that start
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         write_enable_latch_r <= 1'b0;
         program_memory_select_r <= 1'b0;
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_CTRL) && !write_busy_r) begin
         write_enable_latch_r <= reg_wdata[`NVMWP_CTRL_WRITE_ENABLE_LATCH];
         program_memory_select_r <= reg_wdata[`NVMWP_CTRL_PGD];
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_CTRL)) begin
         write_enable_latch_r <= reg_wdata[`NVMWP_CTRL_WRITE_ENABLE_LATCH];
      end
   end

   // Error flag: set on a refused start, hardware set beats software clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         write_error_flag_r <= 1'b0;
      end else if (start_req && !start_ok) begin
         write_error_flag_r <= 1'b1;
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_CTRL)
            && !reg_wdata[`NVMWP_CTRL_WRITE_ERROR_FLAG]) begin
         write_error_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_blocked_r <= 1'b0;
      end else begin
         wr_blocked_r <= start_req && !start_ok;
      end
   end

   // Write timer; no verify step after it ends
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_state_r <= NVMWP_IDLE;
         wr_cnt_r <= '0;
         write_busy_r <= 1'b0;
      end else begin
         case (wr_state_r)
            NVMWP_IDLE: begin
               if (start_req && start_ok) begin
                  wr_state_r <= NVMWP_WRITING;
                  wr_cnt_r <= WC_W'(WRITE_CYCLES - 1);
                  write_busy_r <= 1'b1;
               end
            end
            NVMWP_WRITING: begin
               if (wr_cnt_r == '0) begin
                  wr_state_r <= NVMWP_FINISH;
               end else begin
                  wr_cnt_r <= wr_cnt_r - WC_W'(1);
               end
            end
            NVMWP_FINISH: begin
               wr_state_r <= NVMWP_IDLE;
               write_busy_r <= 1'b0;
            end
            default: wr_state_r <= NVMWP_IDLE;
         endcase
      end
   end
   assign write_end = (wr_state_r == NVMWP_FINISH);

   // Cell strobe only at the end of an accepted write
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mem_wr_strobe <= 1'b0;
         mem_wr_is_prog <= 1'b0;
         mem_wr_addr <= '0;
         mem_wr_data <= '0;
      end else begin
         mem_wr_strobe <= write_end;
         if (write_end) begin
            mem_wr_is_prog <= program_memory_select_r;
            mem_wr_addr <= {addr_hi_r[4:0], addr_lo_r};
            mem_wr_data <= {data_hi_r[5:0], data_lo_r};
         end
      end
   end

   // Done flag: set wins over a firmware clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         nvm_write_done_flag_r <= 1'b0;
      end else if (write_end) begin
         nvm_write_done_flag_r <= 1'b1;
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_PERIPHERAL_FLAG_TWO)) begin
         nvm_write_done_flag_r <= reg_wdata[`NVMWP_PERIPHERAL_FLAG_TWO_DONE];
      end
   end
   assign nvm_write_done_flag = nvm_write_done_flag_r;

   // Address and data stay frozen while a write is running
   // Otherwise the committed word could mix old and new bytes
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         data_lo_r <= '0;
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_DATA_LO) && !write_busy_r) begin
         data_lo_r <= reg_wdata;
      end
   end

   // Only the low six bits reach the cell word
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         data_hi_r <= '0;
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_DATA_HI) && !write_busy_r) begin
         data_hi_r <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         addr_lo_r <= '0;
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_ADDR_LO) && !write_busy_r) begin
         addr_lo_r <= reg_wdata;
      end
   end

   // Only the low five bits reach the cell address
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         addr_hi_r <= '0;
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_ADDR_HI) && !write_busy_r) begin
         addr_hi_r <= reg_wdata;
      end
   end

   // Plain storage; the interrupt logic lives elsewhere
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         interrupt_control_r <= '0;
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_INTERRUPT_CONTROL)) begin
         interrupt_control_r <= reg_wdata;
      end
   end

   // Reserved bits forced low so stray firmware cannot set them
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         peripheral_enable_two_r <= '0;
      end else if (reg_wr && hit(reg_addr, `NVMWP_OFF_PERIPHERAL_ENABLE_TWO)) begin
         peripheral_enable_two_r <= reg_wdata & 8'h1b;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            `NVMWP_OFF_INTERRUPT_CONTROL: reg_rdata <= interrupt_control_r;
            `NVMWP_OFF_PERIPHERAL_FLAG_TWO: reg_rdata <= {3'h0, nvm_write_done_flag_r, 4'h0};
            `NVMWP_OFF_PERIPHERAL_ENABLE_TWO: reg_rdata <= peripheral_enable_two_r;
            `NVMWP_OFF_DATA_LO: reg_rdata <= data_lo_r;
            `NVMWP_OFF_DATA_HI: reg_rdata <= {2'h0, data_hi_r[5:0]};
            `NVMWP_OFF_ADDR_LO: reg_rdata <= addr_lo_r;
            `NVMWP_OFF_ADDR_HI: reg_rdata <= {3'h0, addr_hi_r[4:0]};
            `NVMWP_OFF_CTRL: reg_rdata <= {program_memory_select_r, 3'h0,
               write_error_flag_r, write_enable_latch_r, write_busy_r, 1'b0};
            `NVMWP_OFF_STATUS: reg_rdata <= {2'h0, wr_blocked_r, pwrt_running, cfg_r};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end
endmodule // nvmwp_gate

/* File: pkg/nvmwp_params.svh */
// Offsets, field positions, reset values and timing counts of the write gate
`ifndef NVMWP_PARAMS_SVH
`define NVMWP_PARAMS_SVH
`define NVMWP_OFF_INTERRUPT_CONTROL 9'h00b
`define NVMWP_OFF_PERIPHERAL_FLAG_TWO 9'h00d
`define NVMWP_OFF_PERIPHERAL_ENABLE_TWO 9'h08d
`define NVMWP_OFF_DATA_LO 9'h10c
`define NVMWP_OFF_ADDR_LO 9'h10d
`define NVMWP_OFF_DATA_HI 9'h10e
`define NVMWP_OFF_ADDR_HI 9'h10f
`define NVMWP_OFF_CTRL 9'h18c
`define NVMWP_OFF_UNLOCK 9'h18d
`define NVMWP_OFF_STATUS 9'h18e
`define NVMWP_CTRL_RD 0
`define NVMWP_CTRL_WR 1
`define NVMWP_CTRL_WRITE_ENABLE_LATCH 2
`define NVMWP_CTRL_WRITE_ERROR_FLAG 3
`define NVMWP_CTRL_PGD 7
`define NVMWP_PERIPHERAL_FLAG_TWO_DONE 4
`define NVMWP_UNLOCK_KEY1 8'h55
`define NVMWP_UNLOCK_KEY2 8'haa
`define NVMWP_CFG_ERASED 4'hf
`define NVMWP_WRITE_TIME_US 4
`define NVMWP_CLK_MHZ 25
`define NVMWP_WRITE_CYCLES (`NVMWP_WRITE_TIME_US * `NVMWP_CLK_MHZ)
`define NVMWP_PWRT_TIME_US 72000
`define NVMWP_PWRT_CYCLES (`NVMWP_PWRT_TIME_US * `NVMWP_CLK_MHZ)
`endif

/* File: pkg/nvmwp_pkg.sv */
// Types of the nonvolatile write gate
package nvmwp_pkg;
   typedef enum logic [1:0] {
      NVMWP_LOCKED,
      NVMWP_KEY1_SEEN,
      NVMWP_ARMED
   } nvmwp_unlock_t;
   typedef enum logic [1:0] {
      NVMWP_IDLE,
      NVMWP_WRITING,
      NVMWP_FINISH
   } nvmwp_wr_state_t;
   typedef logic [8:0] nvmwp_addr_t;
endpackage

/* File: bench/nvmwp_gate_checker.sv */
// Port assertions of the nonvolatile write gate
`timescale 1ns/10ps
`include "nvmwp_params.svh"
module nvmwp_gate_checker #(
   parameter int unsigned PWRT_CYCLES = 40,
   parameter int unsigned WRITE_CYCLES = 4
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire nvmwp_pkg::nvmwp_addr_t reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic prog_erase_all,
   input wire logic prog_rd_req,
   input wire logic prog_wr_req,
   input wire logic prog_is_data,
   input wire logic prog_area_protected,
   input wire logic prog_rd_grant,
   input wire logic prog_wr_grant,
   input wire logic fw_prog_rd_grant,
   input wire logic fetch_grant,
   input wire logic [3:0] cfg_bits,
   input wire logic mem_wr_strobe,
   input wire logic mem_wr_is_prog,
   input wire logic nvm_write_done_flag
);
   import nvmwp_pkg::*;
   logic [31:0] pwr_cnt_r;
   logic start_wr, rd_ok, wr_ok;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Timer mirror; assumes the timer is enabled for the whole run
   always_ff @(posedge core_clk) begin
      if (!rst_n) pwr_cnt_r <= '0;
      else if (pwr_cnt_r < PWRT_CYCLES) pwr_cnt_r <= pwr_cnt_r + 1;
   end
   assign start_wr = reg_wr && reg_addr == `NVMWP_OFF_CTRL && reg_wdata[1];
   assign wr_ok = cfg_bits[3] && (prog_is_data || cfg_bits[2:1] == 2'h3);
   assign rd_ok = wr_ok || cfg_bits[3] && cfg_bits[2:1] != 2'h0 && !prog_area_protected;
   chk_port_read: assert property (prog_rd_req |-> prog_rd_grant == rd_ok)
      else $error("bad port read grant");
   chk_port_write: assert property (prog_wr_req |-> prog_wr_grant == wr_ok)
      else $error("bad port write grant");
   chk_cfg_sticky: assert property (|(cfg_bits & ~$past(cfg_bits)) |-> $past(prog_erase_all))
      else $error("protection lifted without erase");
   chk_fetch_open: assert property (rst_n |-> fetch_grant && fw_prog_rd_grant)
      else $error("fetch or firmware read blocked");
   chk_pwrt_block: assert property (pwr_cnt_r < PWRT_CYCLES |-> !mem_wr_strobe)
      else $error("write during power-up delay");
   chk_start_cause: assert property (mem_wr_strobe |-> $past(start_wr, WRITE_CYCLES + 2))
      else $error("commit without start");
   chk_done_flag: assert property ($rose(mem_wr_strobe) |-> nvm_write_done_flag)
      else $error("done flag missing");
   chk_prog_allow: assert property (mem_wr_strobe && mem_wr_is_prog |-> cfg_bits[0])
      else $error("program write while protected");
   cov_data_wr: cover property (mem_wr_strobe && !mem_wr_is_prog);
   cov_prog_wr: cover property (mem_wr_strobe && mem_wr_is_prog);
   cov_erase: cover property ($past(prog_erase_all) && cfg_bits == 4'hf);
endmodule // nvmwp_gate_checker
bind nvmwp_gate nvmwp_gate_checker #(.PWRT_CYCLES(PWRT_CYCLES), .WRITE_CYCLES(WRITE_CYCLES))
   u_nvmwp_gate_checker (.*);

/* File: bench/nvmwp_prog_model.sv */
// Serial programmer model: configuration, erase and access queries
`timescale 1ns/10ps
module nvmwp_prog_model (
   input wire logic core_clk,
   output logic prog_erase_all,
   output logic prog_cfg_wr,
   output logic [3:0] prog_cfg_data,
   output logic prog_rd_req,
   output logic prog_wr_req,
   output logic prog_is_data,
   output logic prog_area_protected
);
   initial begin
      {prog_erase_all, prog_cfg_wr, prog_rd_req, prog_wr_req} = 4'h0;
      {prog_cfg_data, prog_is_data, prog_area_protected} = 6'h00;
   end
   // Released data lines idle inverted so stale values cannot pass
   task automatic pulse(input logic er, input logic [3:0] d);
      @(posedge core_clk);
      {prog_erase_all, prog_cfg_wr, prog_cfg_data} <= {er, !er, d};
      @(posedge core_clk);
      {prog_erase_all, prog_cfg_wr, prog_cfg_data} <= {2'h0, ~d};
      #1;
   endtask
   task automatic sweep;
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         {prog_rd_req, prog_wr_req, prog_area_protected, prog_is_data} <= {2'h3, i[1:0]};
      end
      @(posedge core_clk);
      {prog_rd_req, prog_wr_req} <= 2'h0;
   endtask
endmodule // nvmwp_prog_model

/* File: bench/nvmwp_gate_tb.sv */
// Self-checking bench of the nonvolatile write gate
`timescale 1ns/10ps
`include "nvmwp_params.svh"
module nvmwp_gate_tb;
   import nvmwp_pkg::*;
   localparam int PW = 40;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic pwrt_enable = 1'b1;
   logic fw_area_protected = 1'b0;
   nvmwp_addr_t reg_addr = 9'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, rb;
   logic [3:0] prog_cfg_data, cfg_bits;
   logic [12:0] mem_wr_addr;
   logic [13:0] mem_wr_data;
   logic prog_erase_all, prog_cfg_wr, prog_rd_req, prog_wr_req, prog_is_data;
   logic prog_area_protected, mem_wr_strobe, mem_wr_is_prog, nvm_write_done_flag;
   int bad_count = 0;
   int total_checks = 0;
   always #20 core_clk = ~core_clk;
   nvmwp_gate #(.PWRT_CYCLES(PW), .WRITE_CYCLES(4)) u_nvmwp_gate (.*, .prog_rd_grant(),
      .prog_wr_grant(), .fw_prog_rd_grant(), .fetch_grant());
   nvmwp_prog_model u_nvmwp_prog_model (.*);
   task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input nvmwp_addr_t a, input logic [7:0] d);
      @(posedge core_clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge core_clk);
      {reg_wr, reg_rd} <= 2'h0;
      #1 rb = reg_rdata;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic try_write(input logic pgd, input logic brk, input logic ok);
      int n;
      bus(1'b1, `NVMWP_OFF_ADDR_LO, 8'h3c);
      bus(1'b1, `NVMWP_OFF_ADDR_HI, 8'h15);
      bus(1'b1, `NVMWP_OFF_DATA_LO, 8'ha5);
      bus(1'b1, `NVMWP_OFF_DATA_HI, 8'h2b);
      bus(1'b1, `NVMWP_OFF_CTRL, {pgd, 7'h04});
      bus(1'b1, `NVMWP_OFF_UNLOCK, `NVMWP_UNLOCK_KEY1);
      // A write to any register other than the control register between the keys disarms
      if (brk) bus(1'b1, `NVMWP_OFF_DATA_LO, 8'ha5);
      bus(1'b1, `NVMWP_OFF_UNLOCK, `NVMWP_UNLOCK_KEY2);
      bus(1'b1, `NVMWP_OFF_CTRL, {pgd, 7'h06});
      n = 0;
      while (mem_wr_strobe !== 1'b1 && n < 12) begin
         @(posedge core_clk);
         #1 n++;
      end
      cmp(14'(mem_wr_strobe), 14'(ok));
      cmp(14'(nvm_write_done_flag), 14'(ok));
      if (ok && n == 12) wrap_up();
      if (ok) begin
         // Loop sees the strobe one step after the edge that raises it
         cmp(14'(n), 14'h5);
         cmp({mem_wr_is_prog, mem_wr_addr}, {pgd, 13'h153c});
         cmp(mem_wr_data, 14'h2ba5);
      end
      bus(1'b0, `NVMWP_OFF_CTRL, 8'h00);
      cmp(14'({rb[3], rb[1]}), 14'({!ok, 1'b0}));
      bus(1'b0, `NVMWP_OFF_DATA_LO, 8'h00);
      cmp(14'(rb), 14'ha5);
      bus(1'b1, `NVMWP_OFF_CTRL, 8'h00);
      bus(1'b1, `NVMWP_OFF_PERIPHERAL_FLAG_TWO, 8'h00);
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      cmp(14'(cfg_bits), 14'hf);
      bus(1'b0, `NVMWP_OFF_CTRL, 8'h00);
      cmp(14'(rb[2]), 14'h0);
      bus(1'b1, `NVMWP_OFF_PERIPHERAL_ENABLE_TWO, 8'h10);
      bus(1'b0, 9'h1ff, 8'h00);
      try_write(1'b0, 1'b0, 1'b0);
      repeat (PW) @(posedge core_clk);
      try_write(1'b0, 1'b1, 1'b0);
      u_nvmwp_prog_model.pulse(1'b0, 4'he);
      try_write(1'b1, 1'b0, 1'b0);
      u_nvmwp_prog_model.pulse(1'b1, 4'h0);
      cmp(14'(cfg_bits), 14'hf);
      try_write(1'b1, 1'b0, 1'b1);
      u_nvmwp_prog_model.pulse(1'b0, 4'h7);
      try_write(1'b0, 1'b0, 1'b1);
      u_nvmwp_prog_model.sweep();
      u_nvmwp_prog_model.pulse(1'b1, 4'h0);
      u_nvmwp_prog_model.pulse(1'b0, 4'hd);
      u_nvmwp_prog_model.sweep();
      u_nvmwp_prog_model.pulse(1'b0, 4'hf);
      cmp(14'(cfg_bits), 14'hd);
      wrap_up();
   end
endmodule // nvmwp_gate_tb
